// ==== logic/wct_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module wct_top (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // external clock sources
  input wire logic EXT_CLOCK_PIN,
  input wire logic LP_OSC_CLOCK,
  input wire logic LP_OSC_ENABLE,
  // port pin direction bits for the oscillator pins
  input wire logic [1:0] PORT_DIRECTION_BITS,
  output logic [1:0] PORT_DIRECTION_READ,
  output logic [1:0] OSC_PIN_FORCE_INPUT,
  // capture/compare interface
  input wire logic SPECIAL_EVENT_ONE,
  input wire logic SPECIAL_EVENT_TWO,
  output logic [15:0] COUNT_VALUE,
  output logic UNIT_ONE_USES_WIDE,
  output logic UNIT_TWO_USES_WIDE,
  // overflow
  output logic OVERFLOW_FLAG,
  output logic OVERFLOW_IRQ
);
  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [7:0] control;
  logic [7:0] count_low_byte;
  logic [7:0] count_high;
  logic [7:0] count_high_buffer;
  logic [2:0] prescale;
  logic [1:0] instr_div;
  wct_pkg::wct_ovf_t ovf;
  logic ack;
  logic [31:0] rdata;
  logic ext_rise;

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  // wait state: one cycle of waitrequest before every access completes
  wire req = AVS_READ || AVS_WRITE;
  wire acc = req && ack;
  wire wr = AVS_WRITE && acc;
  wire rd = AVS_READ && acc;
  wire wr_ctl = wr && (AVS_ADDRESS == wct_pkg::OFS_CONTROL);
  wire wr_low = wr && (AVS_ADDRESS == wct_pkg::OFS_COUNT_LOW);
  wire wr_high = wr && (AVS_ADDRESS == wct_pkg::OFS_COUNT_HIGH);
  wire wr_stat = wr && (AVS_ADDRESS == wct_pkg::OFS_STATUS);
  wire rd_low = rd && (AVS_ADDRESS == wct_pkg::OFS_COUNT_LOW);
  wire [7:0] wbyte = AVS_WRITEDATA[7:0];
  wire run = control[wct_pkg::BIT_RUN];
  wire ext_src = control[wct_pkg::BIT_CLK_SRC];
  wire wide = control[wct_pkg::BIT_WIDE];
  wire [1:0] ps_sel = {control[wct_pkg::BIT_PRESCALE_HI], control[wct_pkg::BIT_PRESCALE_LO]};
  wire [1:0] route = {control[wct_pkg::BIT_ROUTE_HI], control[wct_pkg::BIT_ROUTE_LO]};

  // --------------------------------------------------------------------------
  // clock source and prescaler
  // --------------------------------------------------------------------------
  // selected external source; oscillator wins while enabled
  wire ext_in = LP_OSC_ENABLE ? LP_OSC_CLOCK : EXT_CLOCK_PIN;

  wct_edge_detect u_edge (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .bypass(control[wct_pkg::BIT_SYNC_BYPASS]),
    .pin(ext_in),
    .rise(ext_rise)
  );

  // one pulse per instruction cycle
  wire instr_tick = (instr_div == wct_pkg::INSTR_DIV_LAST);
  // sync bit unused on internal source
  wire src_tick = ext_src ? ext_rise : instr_tick;
  wire in_tick = run && src_tick;

  // prescaler terminal count per ratio
  function automatic logic ps_done(input logic [1:0] sel, input logic [2:0] cnt);
    logic [2:0] last;
    last = 3'h0;
    case (sel)
      2'h0: last = 3'h0;
      2'h1: last = 3'h1;
      2'h2: last = 3'h3;
      default: last = 3'h7;
    endcase
    return cnt == last;
  endfunction

  wire ps_hit = in_tick && ps_done(ps_sel, prescale);
  wire [15:0] count = {count_high, count_low_byte};
  wire [15:0] count_inc = count + 16'h0001;
  wire wrap = ps_hit && (count == 16'hffff);

  // special event from a unit whose time base is this counter
  wire unit_one_here = route[1];
  wire unit_two_here = route[1] || route[0];
  wire sev = (SPECIAL_EVENT_ONE && unit_one_here) || (SPECIAL_EVENT_TWO && unit_two_here);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  // bus handshake and control register
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ack <= 1'b0;
      control <= wct_pkg::RST_CONTROL;
      instr_div <= 2'h0;
    end else begin
      ack <= req && !ack;
      instr_div <= instr_div + 2'h1;
      if (wr_ctl) begin
        control <= wbyte;
      end
    end
  end

  // prescaler
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      prescale <= wct_pkg::RST_PRESCALE;
    end else if (wr_low) begin
      prescale <= wct_pkg::RST_PRESCALE;
    end else if (ps_hit) begin
      prescale <= 3'h0;
    end else if (in_tick) begin
      prescale <= prescale + 3'h1;
    end
  end

  // counter low byte; software write beats special event beats count
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      count_low_byte <= wct_pkg::RST_BYTE;
    end else if (wr_low) begin
      count_low_byte <= wbyte;
    end else if (sev) begin
      count_low_byte <= 8'h00;
    end else if (ps_hit) begin
      count_low_byte <= count_inc[7:0];
    end
  end

  // counter high byte
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      count_high <= wct_pkg::RST_BYTE;
    end else if (wide && wr_low) begin
      count_high <= count_high_buffer;
    end else if (!wide && wr_high) begin
      count_high <= wbyte;
    end else if (wr_low) begin
      count_high <= count_high;
    end else if (sev && !(wr_high && !wide)) begin
      count_high <= 8'h00;
    end else if (ps_hit) begin
      count_high <= count_inc[15:8];
    end
  end

  // high byte buffer
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      count_high_buffer <= wct_pkg::RST_BYTE;
    end else if (wide && wr_high) begin
      count_high_buffer <= wbyte;
    end else if (wide && rd_low) begin
      count_high_buffer <= count_high;
    end
  end

  // overflow status; hardware set beats software clear
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ovf <= '0;
    end else begin
      if (wr_stat) begin
        ovf.irq_enable <= AVS_WRITEDATA[wct_pkg::BIT_OVF_IRQ_EN];
      end
      if (wrap && !sev) begin
        ovf.flag <= 1'b1;
      end else if (wr_stat && AVS_WRITEDATA[wct_pkg::BIT_OVF_FLAG]) begin
        ovf.flag <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  // high address reads buffer in wide mode, true byte otherwise
  wire [7:0] high_view = wide ? count_high_buffer : count_high;
  wire [7:0] stat_view = {6'h00, ovf.irq_enable, ovf.flag};
  wire [7:0] rsel = (AVS_ADDRESS == wct_pkg::OFS_CONTROL) ? control :
                    (AVS_ADDRESS == wct_pkg::OFS_COUNT_LOW) ? count_low_byte :
                    (AVS_ADDRESS == wct_pkg::OFS_COUNT_HIGH) ? high_view :
                    (AVS_ADDRESS == wct_pkg::OFS_STATUS) ? stat_view : 8'h00;

  // read data registered at the end of the wait cycle, one edge before completion
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rdata <= 32'h0000_0000;
    end else if (AVS_READ && !ack) begin
      rdata <= {24'h000000, rsel};
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign AVS_READDATA = rdata;
  assign AVS_WAITREQUEST = req && !ack;
  assign OSC_PIN_FORCE_INPUT = {LP_OSC_ENABLE, LP_OSC_ENABLE};
  assign PORT_DIRECTION_READ = LP_OSC_ENABLE ? 2'h0 : PORT_DIRECTION_BITS;
  assign COUNT_VALUE = count;
  assign UNIT_ONE_USES_WIDE = unit_one_here;
  assign UNIT_TWO_USES_WIDE = unit_two_here;
  assign OVERFLOW_FLAG = ovf.flag;
  assign OVERFLOW_IRQ = ovf.flag && ovf.irq_enable;
endmodule
`default_nettype wire

// ==== shared/wct_pkg.sv ====
`default_nettype none
// ----------------------------------------------------------------------------
// wide counter shared definitions
// ----------------------------------------------------------------------------
package wct_pkg;
  // register byte offsets on the avalon word bus
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_COUNT_LOW = 4'h4;
  localparam logic [3:0] OFS_COUNT_HIGH = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  // control field positions
  localparam int BIT_RUN = 0;
  localparam int BIT_CLK_SRC = 1;
  localparam int BIT_SYNC_BYPASS = 2;
  localparam int BIT_ROUTE_LO = 3;
  localparam int BIT_PRESCALE_LO = 4;
  localparam int BIT_PRESCALE_HI = 5;
  localparam int BIT_ROUTE_HI = 6;
  localparam int BIT_WIDE = 7;
  // status field positions
  localparam int BIT_OVF_FLAG = 0;
  localparam int BIT_OVF_IRQ_EN = 1;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_PRESCALE = 3'h0;
  // instruction cycle is the system clock divided by four
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  // sticky overflow flag cleared by writing one; irq enable written directly
  typedef struct packed {
    logic flag;
    logic irq_enable;
  } wct_ovf_t;
endpackage
`default_nettype wire

// ==== logic/wct_edge_detect.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// external clock edge qualifier
// ----------------------------------------------------------------------------
module wct_edge_detect (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic bypass,
  // pin
  input wire logic pin,
  // qualified rising edge
  output logic rise
);
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic last;
  logic armed;
  // only the second stage reads the first; bypass skips the extra delay stage
  wire sampled = bypass ? sync_b : sync_c;

  // two-stage synchroniser plus one delay stage for the synchronised path
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
      last <= 1'b0;
      armed <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
      last <= sampled;
      if (last && !sampled) begin
        armed <= 1'b1;
      end
    end
  end

  assign rise = armed && sampled && !last;
endmodule
`default_nettype wire

// ==== bench/wct_top_props.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----
// port checks
// ----
module wct_top_props (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // bus
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  // pins
  input wire logic LP_OSC_ENABLE,
  input wire logic [1:0] PORT_DIRECTION_BITS,
  input wire logic [1:0] PORT_DIRECTION_READ,
  input wire logic [1:0] OSC_PIN_FORCE_INPUT,
  // counter side
  input wire logic SPECIAL_EVENT_ONE,
  input wire logic SPECIAL_EVENT_TWO,
  input wire logic [15:0] COUNT_VALUE,
  input wire logic UNIT_ONE_USES_WIDE,
  input wire logic UNIT_TWO_USES_WIDE,
  input wire logic OVERFLOW_FLAG,
  input wire logic OVERFLOW_IRQ
);
  // one clock domain, quiet in reset
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  // bus answer, pin and route relations
  a_one_wait: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("read not answered after one wait");
  a_pins_forced: assert property (OSC_PIN_FORCE_INPUT == {2{LP_OSC_ENABLE}})
    else $error("pin force wrong");
  a_dir_masked: assert property (PORT_DIRECTION_READ == (LP_OSC_ENABLE ? 2'h0 : PORT_DIRECTION_BITS))
    else $error("direction readback wrong");
  a_route_nest: assert property (UNIT_ONE_USES_WIDE |-> UNIT_TWO_USES_WIDE)
    else $error("route decode wrong");
  // counter moves by one or to zero unless written
  a_count_step: assert property ($past(RST_N) && !$past(AVS_WRITE) && !$stable(COUNT_VALUE)
    |-> COUNT_VALUE == $past(COUNT_VALUE) + 16'h1 || COUNT_VALUE == 16'h0)
    else $error("count jumped");
  a_wrap_flag: assert property ($past(RST_N) && !$past(AVS_WRITE) && $past(COUNT_VALUE) == 16'hffff
    && !$past(SPECIAL_EVENT_ONE || SPECIAL_EVENT_TWO) && COUNT_VALUE == 16'h0 |-> ##[0:1] OVERFLOW_FLAG)
    else $error("wrap did not flag");
  a_flag_sticky: assert property ($fell(OVERFLOW_FLAG) |-> $past(AVS_WRITE))
    else $error("flag dropped without write");
  a_irq_gated: assert property (OVERFLOW_IRQ |-> OVERFLOW_FLAG)
    else $error("irq without flag");
  a_event_zero: assert property ((SPECIAL_EVENT_ONE && UNIT_ONE_USES_WIDE
    || SPECIAL_EVENT_TWO && UNIT_TWO_USES_WIDE) && !AVS_WRITE |=> COUNT_VALUE == 16'h0)
    else $error("event did not zero count");
endmodule
bind wct_top wct_top_props u_props (.CLK_SYS, .RST_N, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST,
  .LP_OSC_ENABLE, .PORT_DIRECTION_BITS, .PORT_DIRECTION_READ, .OSC_PIN_FORCE_INPUT,
  .SPECIAL_EVENT_ONE, .SPECIAL_EVENT_TWO, .COUNT_VALUE, .UNIT_ONE_USES_WIDE,
  .UNIT_TWO_USES_WIDE, .OVERFLOW_FLAG, .OVERFLOW_IRQ);
`default_nettype wire

// ==== bench/wct_ext_src.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----
// external clock source model
// ----
module wct_ext_src (
  // clock
  input wire logic clk,
  // source choice
  input wire logic use_osc,
  // driven lines
  output logic pin,
  output logic osc
);
  // lines rest low between bursts; core clock never taken from here
  initial begin
    pin = 1'b0;
    osc = 1'b0;
  end
  // n rising edges, each level held for half cycles
  task automatic burst(input int n, input int half);
    for (int i = 0; i < 2 * n; i++) begin
      repeat (half) @(posedge clk);
      if (use_osc) begin
        osc <= ~osc;
      end else begin
        pin <= ~pin;
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== bench/wct_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----
// wide counter bench
// ----
module wct_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic osc_en = 1'b0;
  logic use_osc = 1'b0;
  logic [1:0] dir_bits = 2'h0;
  logic ev1 = 1'b0;
  logic ev2 = 1'b0;
  logic [31:0] rdat;
  logic wreq, pin, osc, one_w, two_w, ovf, irq;
  logic [1:0] dir_rd, force_in;
  logic [15:0] cnt, hold;
  logic [31:0] exp_q[$];
  logic [7:0] rv;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  localparam logic [3:0] CTL = wct_pkg::OFS_CONTROL;
  localparam logic [3:0] LO = wct_pkg::OFS_COUNT_LOW;
  localparam logic [3:0] HI = wct_pkg::OFS_COUNT_HIGH;
  localparam logic [3:0] ST = wct_pkg::OFS_STATUS;
  // 50 ns clock
  initial begin
    forever #25 clk = ~clk;
  end
  wct_top uut (.CLK_SYS(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .EXT_CLOCK_PIN(pin),
    .LP_OSC_CLOCK(osc), .LP_OSC_ENABLE(osc_en), .PORT_DIRECTION_BITS(dir_bits),
    .PORT_DIRECTION_READ(dir_rd), .OSC_PIN_FORCE_INPUT(force_in), .SPECIAL_EVENT_ONE(ev1),
    .SPECIAL_EVENT_TWO(ev2), .COUNT_VALUE(cnt), .UNIT_ONE_USES_WIDE(one_w),
    .UNIT_TWO_USES_WIDE(two_w), .OVERFLOW_FLAG(ovf), .OVERFLOW_IRQ(irq));
  wct_ext_src src (.clk(clk), .use_osc(use_osc), .pin(pin), .osc(osc));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // bus cycles held until waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= {24'h0, d};
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask
  // cycles between two count steps
  task automatic step_len();
    hold = cnt;
    for (n = 0; n < 200 && cnt === hold; n++) @(posedge clk);
    hold = cnt;
    for (n = 0; n < 200 && cnt === hold; n++) @(posedge clk);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // read data against oldest note
  always @(posedge clk) begin
    if (rd === 1'b1 && wreq === 1'b0) chk("read data", exp_q.pop_front(), rdat);
  end
  // hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  // ----
  // tests
  // ----
  initial begin
    void'($urandom(55601));
    do_reset();
    rd_reg(CTL, 8'h00);
    rd_reg(LO, 8'h00);
    rd_reg(HI, 8'h00);
    rd_reg(4'h2, 8'h00);
    $display("test 1 done");
    rv = 8'($urandom()) & 8'h7e;
    bus(1'b1, CTL, rv);
    rd_reg(CTL, rv);
    bus(1'b1, LO, 8'h5a);
    bus(1'b1, HI, 8'h3c);
    repeat (20) @(posedge clk);
    chk("count", 32'h3c5a, 32'(cnt));
    bus(1'b1, CTL, 8'h80);
    rv = 8'($urandom());
    bus(1'b1, HI, rv);
    @(negedge clk);
    chk("count", 32'h3c5a, 32'(cnt));
    bus(1'b1, LO, 8'hcd);
    @(negedge clk);
    chk("count", 32'({rv, 8'hcd}), 32'(cnt));
    rd_reg(LO, 8'hcd);
    rd_reg(HI, rv);
    bus(1'b1, HI, 8'h11);
    rd_reg(HI, 8'h11);
    $display("test 2 done");
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, CTL, 8'h04 | 8'(p << 4));
      bus(1'b1, LO, 8'h00);
      bus(1'b1, CTL, 8'h05 | 8'(p << 4));
      step_len();
      chk("interval", 32'(4 << p), 32'(n));
    end
    bus(1'b1, CTL, 8'h04);
    @(negedge clk);
    hold = cnt;
    repeat (40) @(posedge clk);
    chk("halted", 32'(hold), 32'(cnt));
    bus(1'b1, CTL, 8'h80);
    bus(1'b1, HI, 8'hff);
    bus(1'b1, LO, 8'hfc);
    bus(1'b1, CTL, 8'h81);
    for (n = 0; n < 100 && ovf !== 1'b1; n++) @(posedge clk);
    @(negedge clk);
    chk("irq", 32'h0, 32'(irq));
    rd_reg(ST, 8'h01);
    bus(1'b1, CTL, 8'h80);
    bus(1'b1, ST, 8'h02);
    @(negedge clk);
    chk("irq", 32'h1, 32'(irq));
    bus(1'b1, ST, 8'h03);
    rd_reg(ST, 8'h02);
    $display("test 3 done");
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, CTL, {1'b0, r[1], 2'h0, r[0], 3'h0});
      @(negedge clk);
      chk("route", 32'({r[1], r != 0}), 32'({one_w, two_w}));
      for (int e = 0; e < 2; e++) begin
        bus(1'b1, LO, 8'h77);
        @(posedge clk);
        ev1 <= (e == 0);
        ev2 <= (e == 1);
        @(posedge clk);
        ev1 <= 1'b0;
        ev2 <= 1'b0;
        @(negedge clk);
        chk("event", ((e == 0) ? r[1] : r != 0) ? 32'h0 : 32'h77, 32'(cnt[7:0]));
        chk("flag", 32'h0, 32'(ovf));
      end
    end
    $display("test 4 done");
    for (int m = 0; m < 3; m++) begin
      do_reset();
      osc_en <= (m == 2);
      use_osc <= (m == 2);
      dir_bits <= 2'h3;
      bus(1'b1, CTL, 8'h03 | (8'(m == 1) << 2));
      src.burst(5, 4);
      repeat (10) @(posedge clk);
      chk("ext count", 32'h4, 32'(cnt));
      chk("pins", (m == 2) ? 32'h0c : 32'h03, 32'({force_in, dir_rd}));
    end
    $display("test 5 done");
    complete_run();
  end
endmodule
`default_nettype wire
